// ==== design/pmad_top.v ====
/*
  bus-master abort reporting, bus parking and storage dma command
  decode for a two-function pci device, plus config select and the
  interrupt pin fields.
  assumes a pci core outside decodes bus cycles into single-cycle
  register strobes and reports master and target aborts as pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pmad_consts.vh"
module pmad_top #(
  parameter XFER_W = 16
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // arbitration, storage then network pair
  input wire i_grant_storage_fn_n,
  input wire i_grant_network_fn_n,
  input wire i_bus_idle,
  input wire i_net_req,
  // register access strobe from the host slave path
  input wire i_acc_valid,
  input wire i_acc_write,
  input wire i_acc_cfg,
  input wire i_config_select_storage,
  input wire i_config_select_network,
  input wire [7:0] i_acc_addr,
  input wire [3:0] i_acc_be,
  input wire [31:0] i_acc_wdata,
  // abort, interrupt and done events from the master engine
  input wire i_tabort_sto,
  input wire i_mabort_sto,
  input wire i_tabort_net,
  input wire i_mabort_net,
  input wire i_net_irq_evt,
  input wire i_sto_done_evt,
  // outputs
  output reg o_request_storage_fn_n,
  output reg o_request_network_fn_n,
  output reg o_park_oe,
  output reg [31:0] o_acc_rdata,
  output reg o_acc_hit,
  output reg o_irq_storage_fn_oe,
  output reg o_irq_network_fn_oe,
  output reg o_dma_active,
  output reg [XFER_W-1:0] o_dma_count
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_FLUSH = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] dma_command_field_ff;
  reg dma_abort_ff;
  reg dma_done_ff;
  reg net_irq_ff;
  reg [XFER_W-1:0] count_ff;
  wire [15:0] sto_status;
  wire [15:0] net_status;
  reg [15:0] sto_clr;
  reg [15:0] net_clr;
  reg cmd_wr;
  reg sto_sel;
  reg net_sel;
  reg [31:0] rdata;

  // config access decode; only one function answers per cycle
  always @* begin
    sto_sel = i_acc_valid & i_acc_cfg & i_config_select_storage; // R9
    net_sel = i_acc_valid & i_acc_cfg & i_config_select_network & ~i_config_select_storage; // R9
    cmd_wr = i_acc_valid & ~i_acc_cfg & i_acc_write & i_acc_be[0]
      & (i_acc_addr == `PMAD_OFS_DMA_CMD); // R8
    sto_clr = 16'h0000;
    net_clr = 16'h0000;
    if (i_acc_write && (i_acc_addr == (`PMAD_OFS_PCI_STATUS & 8'hfc)) && i_acc_be[3]) begin
      if (sto_sel) begin
        sto_clr = {i_acc_wdata[31:24], 8'h00};
      end
      if (net_sel) begin
        net_clr = {i_acc_wdata[31:24], 8'h00};
      end
    end
  end

  // one flag block per function, each on its own config space
  pmad_fn_status u_sto_status (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_tabort(i_tabort_sto),
    .i_mabort(i_mabort_sto),
    .i_clr(sto_clr),
    .o_status(sto_status)
  );
  pmad_fn_status u_net_status (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_tabort(i_tabort_net),
    .i_mabort(i_mabort_net),
    .i_clr(net_clr),
    .o_status(net_status)
  );

  // dma state machine; aborts end the transfer without an interrupt
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_wr && i_acc_wdata[1:0] == `PMAD_CMD_START) begin
          nxt_state = ST_RUN; // R6
        end
      end
      ST_RUN: begin
        if (cmd_wr && i_acc_wdata[1:0] == `PMAD_CMD_FLUSH) begin
          nxt_state = ST_FLUSH; // R6
        end
      end
      ST_FLUSH: begin
        if (i_sto_done_evt) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (cmd_wr && (i_acc_wdata[1:0] == `PMAD_CMD_IDLE || i_acc_wdata[1:0] == `PMAD_CMD_ABORT)) begin
      nxt_state = ST_IDLE; // R6 R7
    end
    if (i_tabort_sto || i_mabort_sto || (state_ff == ST_RUN && i_sto_done_evt)) begin
      nxt_state = ST_IDLE;
    end
  end

  // dma registers; idle write touches no status flag
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      dma_command_field_ff <= `PMAD_CMD_IDLE;
      dma_abort_ff <= 1'b0;
      dma_done_ff <= 1'b0;
      count_ff <= {XFER_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      if (cmd_wr) begin
        dma_command_field_ff <= i_acc_wdata[1:0]; // R6
      end
      if (nxt_state == ST_IDLE) begin
        count_ff <= count_ff; // R7
      end else begin
        count_ff <= count_ff + {{(XFER_W-1){1'b0}}, 1'b1};
      end
      // a status read clears the sticky flags, but a new abort wins
      if (i_tabort_sto || i_mabort_sto) begin
        dma_abort_ff <= 1'b1; // R2 R4 R13
      end else if (i_acc_valid && !i_acc_cfg && !i_acc_write
                   && i_acc_addr == `PMAD_OFS_DMA_STATUS) begin
        dma_abort_ff <= 1'b0;
      end
      if (i_sto_done_evt) begin
        dma_done_ff <= 1'b1;
      end else if (i_acc_valid && !i_acc_cfg && !i_acc_write
                   && i_acc_addr == `PMAD_OFS_DMA_STATUS) begin
        dma_done_ff <= 1'b0;
      end
    end
  end

  // read mux; unmapped offsets return zero
  always @* begin
    rdata = 32'h0000_0000;
    if (sto_sel || net_sel) begin
      if (i_acc_addr == (`PMAD_OFS_PCI_STATUS & 8'hfc)) begin
        rdata = {sto_sel ? sto_status : net_status, 16'h0000};
      end else if (i_acc_addr == (`PMAD_OFS_INT_PIN & 8'hfc)) begin
        rdata = {16'h0000, sto_sel ? `PMAD_STO_INT_PIN : `PMAD_NET_INT_PIN, 8'h00}; // R10
      end
    end else if (!i_acc_cfg) begin
      if (i_acc_addr == `PMAD_OFS_DMA_STATUS) begin
        rdata[`PMAD_BIT_DMA_ABORT] = dma_abort_ff;
        rdata[`PMAD_BIT_DMA_DONE] = dma_done_ff;
      end else if (i_acc_addr == `PMAD_OFS_DMA_CMD) begin
        rdata[1:0] = dma_command_field_ff;
      end
    end
  end

  // registered outputs; parking only when storage grant idles unrequested
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_request_storage_fn_n <= 1'b1;
      o_request_network_fn_n <= 1'b1;
      o_park_oe <= 1'b0;
      o_acc_rdata <= 32'h0000_0000;
      o_acc_hit <= 1'b0;
      o_irq_storage_fn_oe <= 1'b0;
      o_irq_network_fn_oe <= 1'b0;
      o_dma_active <= 1'b0;
      o_dma_count <= {XFER_W{1'b0}};
      net_irq_ff <= 1'b0;
    end else begin
      o_request_storage_fn_n <= ~(nxt_state != ST_IDLE); // R12
      o_request_network_fn_n <= ~i_net_req; // R12
      o_park_oe <= i_bus_idle & ~i_grant_storage_fn_n & o_request_storage_fn_n; // R1
      o_acc_rdata <= rdata;
      o_acc_hit <= i_acc_valid & ~i_acc_write;
      // aborts never raise the storage line, only normal completion
      o_irq_storage_fn_oe <= dma_done_ff; // R2 R4 R11
      net_irq_ff <= i_net_irq_evt | (net_irq_ff & ~(net_sel & i_acc_write));
      o_irq_network_fn_oe <= net_irq_ff; // R11
      o_dma_active <= (nxt_state != ST_IDLE);
      o_dma_count <= count_ff;
    end
  end
endmodule
`default_nettype wire

// ==== design/pmad_consts.vh ====
/*
  constants for the pci master-abort and dma status block: register
  offsets, bit positions, reset values and command encodings.
  assumes inclusion by bare name from design files only.
*/
// Notes on behaviour
// (R1) idle bus, storage grant, no request: drive lines
// (R2) storage target abort: no irq, set dma abort
// (R3) target abort sets function status bit 12
// (R4) storage master abort: no irq, set abort
// (R5) master abort sets function status bit 13
// (R6) two-bit command: idle, flush, start, abort
// (R7) idle command stops transfer, keeps status
// (R8) host slave access single cycle, 8/16/32 bit
// (R9) either config select marks config access
// (R10) network interrupt pin reads 02h after reset
// (R11) storage irq first line, network second
// (R12) separate request/grant pair per function
// (R13) abort flags stay until software clears
`ifndef PMAD_CONSTS_VH
`define PMAD_CONSTS_VH
`define PMAD_OFS_DMA_STATUS 8'h54
`define PMAD_OFS_DMA_CMD 8'h40
`define PMAD_OFS_PCI_STATUS 8'h06
`define PMAD_OFS_INT_PIN 8'h3d
`define PMAD_BIT_DMA_ABORT 2
`define PMAD_BIT_DMA_DONE 3
`define PMAD_BIT_RTABT 12
`define PMAD_BIT_RMABT 13
`define PMAD_NET_INT_PIN 8'h02
`define PMAD_STO_INT_PIN 8'h01
`define PMAD_CMD_IDLE 2'h0
`define PMAD_CMD_FLUSH 2'h1
`define PMAD_CMD_START 2'h2
`define PMAD_CMD_ABORT 2'h3
`define PMAD_FN_STO 1'h0
`define PMAD_FN_NET 1'h1
`endif

// ==== design/pmad_fn_status.v ====
/*
  per-function pci status flags: received target and master abort.
  assumes abort events are one-cycle pulses and the clear mask comes
  from a write-one-to-clear config write.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pmad_consts.vh"
module pmad_fn_status (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // events and clear
  input wire i_tabort,
  input wire i_mabort,
  input wire [15:0] i_clr,
  // status out
  output wire [15:0] o_status
);
  reg rt_ff;
  reg rm_ff;
  // set wins over clear so an abort in the clear cycle is kept
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      rt_ff <= 1'b0;
      rm_ff <= 1'b0;
    end else begin
      rt_ff <= i_tabort | (rt_ff & ~i_clr[`PMAD_BIT_RTABT]); // R3 R13
      rm_ff <= i_mabort | (rm_ff & ~i_clr[`PMAD_BIT_RMABT]); // R5 R13
    end
  end
  assign o_status = {2'h0, rm_ff, rt_ff, 12'h000};
endmodule
`default_nettype wire

// ==== tb/pmad_top_props.sv ====
/* port checker for pmad_top, bound at the foot.
   assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module pmad_props (
  // clock and reset
  input wire logic i_core_clk, input wire logic i_rst,
  // watched inputs
  input wire logic i_grant_storage_fn_n, input wire logic i_bus_idle,
  input wire logic i_acc_valid, input wire logic i_acc_write, input wire logic i_acc_cfg,
  input wire logic i_config_select_storage, input wire logic i_config_select_network,
  input wire logic i_tabort_sto, input wire logic i_mabort_sto,
  input wire logic i_net_irq_evt, input wire logic i_sto_done_evt,
  // watched outputs
  input wire logic o_request_storage_fn_n, input wire logic o_park_oe,
  input wire logic o_acc_hit, input wire logic o_dma_active,
  input wire logic o_irq_storage_fn_oe, input wire logic o_irq_network_fn_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // either abort seen by the storage master
  logic sto_abt;
  assign sto_abt = i_tabort_sto || i_mabort_sto;
  a_park_drive: assert property (i_bus_idle && !i_grant_storage_fn_n &&
    o_request_storage_fn_n |=> o_park_oe) else $error("parked lines not driven");
  a_park_cause: assert property (o_park_oe |->
    $past(i_bus_idle && !i_grant_storage_fn_n)) else $error("lines driven unparked");
  a_abort_noirq: assert property (sto_abt && !i_sto_done_evt && !$past(i_sto_done_evt) |=>
    !$rose(o_irq_storage_fn_oe)) else $error("abort raised storage irq");
  a_abort_stops: assert property (sto_abt |-> ##[1:2] !o_dma_active)
    else $error("dma still active after abort");
  a_cfg_hit: assert property (i_acc_valid && !i_acc_write && i_acc_cfg &&
    (i_config_select_storage || i_config_select_network) |=> o_acc_hit)
    else $error("selected config read not answered");
  a_net_irq_evt: assert property (i_net_irq_evt |-> ##[1:2] o_irq_network_fn_oe)
    else $error("network irq missing");
  a_net_irq_src: assert property ($rose(o_irq_network_fn_oe) |->
    $past(i_net_irq_evt) || $past(i_net_irq_evt, 2)) else $error("network irq unprompted");
  a_sto_irq_src: assert property ($rose(o_irq_storage_fn_oe) |->
    $past(i_sto_done_evt) || $past(i_sto_done_evt, 2)) else $error("storage irq unprompted");
  c_park: cover property (o_park_oe);
  c_run: cover property ($rose(o_dma_active));
  c_net_irq: cover property ($rose(o_irq_network_fn_oe));
endmodule
bind pmad_top pmad_props chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_grant_storage_fn_n(i_grant_storage_fn_n), .i_bus_idle(i_bus_idle),
  .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write), .i_acc_cfg(i_acc_cfg),
  .i_config_select_storage(i_config_select_storage),
  .i_config_select_network(i_config_select_network), .i_tabort_sto(i_tabort_sto),
  .i_mabort_sto(i_mabort_sto), .i_net_irq_evt(i_net_irq_evt),
  .i_sto_done_evt(i_sto_done_evt), .o_request_storage_fn_n(o_request_storage_fn_n),
  .o_park_oe(o_park_oe), .o_acc_hit(o_acc_hit), .o_dma_active(o_dma_active),
  .o_irq_storage_fn_oe(o_irq_storage_fn_oe), .o_irq_network_fn_oe(o_irq_network_fn_oe));
`default_nettype wire

// ==== tb/pmad_arb_model.sv ====
/* arbiter model with one request and grant pair per function.
   assumes active-low request and grant levels. */
`timescale 1ns/10ps
`default_nettype none
module pmad_arb_model (
  // clock and park control
  input wire logic i_clk, input wire logic i_park,
  // requests in, grants and bus state out
  input wire logic i_req_sto_n, input wire logic i_req_net_n,
  output logic o_gnt_sto_n, output logic o_gnt_net_n, output logic o_idle
);
  // pairs served apart, a cycle late; parking grants storage unasked
  always @(posedge i_clk) begin
    o_gnt_sto_n <= i_req_sto_n && !i_park;
    o_gnt_net_n <= i_req_net_n;
  end
  // bus idle while neither function asks for it
  assign o_idle = i_req_sto_n && i_req_net_n;
endmodule
`default_nettype wire

// ==== tb/pmad_top_tb.sv ====
/* self-checking bench for pmad_top: accesses, abort events, parking.
   assumes the checker is bound and the arbiter model supplies grants. */
`timescale 1ns/10ps
`default_nettype none
module pmad_top_tb;
  logic clk, rst, vld, wr, cfg, ss, sn, park, nreq, gs_n, gn_n, idle, rs_n, rn_n;
  logic pk, hit, is, inet, act;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rd;
  logic [5:0] ev;
  logic [15:0] cnt, c0;
  int fails, checked;
  pmad_arb_model arb_u (.i_clk(clk), .i_park(park), .i_req_sto_n(rs_n),
    .i_req_net_n(rn_n), .o_gnt_sto_n(gs_n), .o_gnt_net_n(gn_n), .o_idle(idle));
  pmad_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_grant_storage_fn_n(gs_n),
    .i_grant_network_fn_n(gn_n), .i_bus_idle(idle), .i_net_req(nreq), .i_acc_valid(vld),
    .i_acc_write(wr), .i_acc_cfg(cfg), .i_config_select_storage(ss),
    .i_config_select_network(sn), .i_acc_addr(adr), .i_acc_be(be), .i_acc_wdata(wd),
    .i_tabort_sto(ev[0]), .i_mabort_sto(ev[1]), .i_tabort_net(ev[2]),
    .i_mabort_net(ev[3]), .i_net_irq_evt(ev[4]), .i_sto_done_evt(ev[5]),
    .o_request_storage_fn_n(rs_n), .o_request_network_fn_n(rn_n), .o_park_oe(pk),
    .o_acc_rdata(rd), .o_acc_hit(hit), .o_irq_storage_fn_oe(is),
    .o_irq_network_fn_oe(inet), .o_dma_active(act), .o_dma_count(cnt));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single-cycle access; its answer has landed by the next falling edge
  task automatic acc(input logic w, c, s, n, input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d);
    @(negedge clk);
    {vld, wr, cfg, ss, sn, adr, be, wd} = {1'b1, w, c, s, n, a, b, d};
    @(negedge clk);
    vld = 0;
  endtask
  task automatic rdc(input logic c, s, n, input logic [7:0] a, input logic [31:0] m, e);
    acc(1'b0, c, s, n, a, 4'hf, 32'h0);
    chk(rd & m, e);
  endtask
  // one-cycle event pulse, then a spare cycle for registered effects
  task automatic pulse(input logic [5:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 0;
    @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // about 90 cycles of tests; cut off well beyond that
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    {vld, wr, cfg, ss, sn, adr, be, wd, ev, park, nreq} = '0;
    rst = 1;
    repeat (10) @(negedge clk);
    rst = 0;
    rdc(1, 0, 1, 8'h3c, 32'hff00, 32'h0200);
    rdc(1, 1, 0, 8'h3c, 32'hff00, 32'h0100);
    acc(1, 0, 0, 0, 8'h40, 4'h1, 32'h2);
    pulse(6'h01);
    chk(is, 0);
    rdc(0, 0, 0, 8'h54, 32'h4, 32'h4);
    rdc(1, 1, 0, 8'h04, 32'h30000000, 32'h10000000);
    rdc(1, 1, 0, 8'h04, 32'h30000000, 32'h10000000);
    acc(1, 1, 1, 0, 8'h04, 4'h8, 32'h10000000);
    rdc(1, 1, 0, 8'h04, 32'h30000000, 32'h0);
    pulse(6'h02);
    chk(is, 0);
    rdc(0, 0, 0, 8'h54, 32'h4, 32'h4);
    rdc(1, 1, 0, 8'h04, 32'h30000000, 32'h20000000);
    acc(1, 1, 1, 0, 8'h04, 4'hc, 32'h20000000);
    pulse(6'h0c);
    rdc(1, 0, 1, 8'h04, 32'h30000000, 32'h30000000);
    rdc(1, 1, 0, 8'h04, 32'h30000000, 32'h0);
    // abort while running, then every command; flush from run keeps the engine busy
    acc(1, 0, 0, 0, 8'h40, 4'h1, 32'h2);
    pulse(6'h01);
    for (int k = 0; k < 4; k++) begin
      acc(1, 0, 0, 0, 8'h40, 4'h1, 32'h2);
      acc(1, 0, 0, 0, 8'h40, 4'h1, k);
      @(negedge clk);
      chk(act, k == 1 || k == 2);
    end
    rdc(0, 0, 0, 8'h54, 32'h4, 32'h4);
    pulse(6'h10);
    chk({is, inet}, 2'h1);
    acc(1, 0, 0, 0, 8'h40, 4'h1, 32'h2);
    c0 = cnt;
    repeat (4) @(negedge clk);
    chk(cnt, c0 + 16'h0004);
    pulse(6'h20);
    chk(is, 1);
    park = 1;
    repeat (3) @(negedge clk);
    chk(pk, 1);
    park = 0;
    nreq = 1;
    repeat (3) @(negedge clk);
    chk({rn_n, pk}, 2'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
